// ---- video_raster_timing.sv ----
// Purpose: character-cell raster generator with pixel pipeline and shared video memory slots
// Assumes: dot rate made by a fractional enable from clk_in; strobes from the cpu are async
// Notes: cpu address and write data must be stable while its strobe is low
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] pixel timing runs at a 12.324 MHz dot rate, one dot per period
// [R2] character clock is the dot rate divided by eight
// [R3] normal raster is 24 rows of 10 scans with 80 cells per row
// [R4] 60 Hz setting uses 262 blanked scan lines per frame
// [R5] 50 Hz setting keeps 24 by 10 and uses 312 blanked lines
// [R6] seven-bit cell column count is output
// [R7] scan counter steps through the scans of a row then wraps
// [R8] five-bit text row count is output
// [R9] blank during both retraces; line, frame and composite sync outputs
// [R10] selected host strobe writes indexed register or moves cursor address
// [R11] cursor marker asserts while scan is at the cursor location
// [R12] counting continues through blanking so every line is equal length
// [R13] one line sync per scan line; frame sync times vertical motion
// [R14] memory data registered, rom addressed next cell, pixels trail two cells
// [R15] sync, blank and cursor delayed twice plus one common output stage
// [R16] each character time has a display half and a cpu half
// [R17] cpu half used only when the cpu has an access pending
// [R18] display half reads memory at the raster counter address
// [R19] address mux picks cpu address or raster address per slot
// [R20] raster visits every character position in sequence each frame
// [R21] cpu display access returns wait until it completes in cpu slot
// [R22] reset clears counters; syncs inactive until timing is programmed
// [R23] cpu slot is a fixed half of each character time
module video_raster_timing (
  input wire logic clk_in,            // system clock, 100 MHz
  input wire logic reset_in,          // synchronous reset, active high
  input wire logic psel,              // apb select
  input wire logic penable,           // apb access phase
  input wire logic pwrite,            // apb direction
  input wire logic [7:0] paddr,       // apb byte address
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error, unmapped read or write above the status offset
  input wire logic display_select_n_in, // cpu display select, low active
  input wire logic io_write_n_in,     // cpu io write, low active
  input wire logic io_read_n_in,      // cpu io read, low active
  input wire logic [11:0] cpu_addr_in, // cpu video memory address
  input wire logic [7:0] cpu_wdata_in, // cpu write data
  output logic [7:0] cpu_rdata_out,   // data read for the cpu
  output logic wait_out,              // wait state to the cpu
  output logic [11:0] vram_addr_out,  // video memory address
  output logic [7:0] vram_wdata_out,  // video memory write data
  output logic vram_we_out,           // video memory write enable
  input wire logic [7:0] vram_rdata_in, // video memory read data
  output logic [10:0] rom_addr_out,   // character rom address
  input wire logic [7:0] rom_data_in, // character rom row of dots
  output logic [6:0] cell_column_count_out, // cell column
  output logic [3:0] scan_line_count_out, // scan within row
  output logic [4:0] text_row_count_out, // text row
  output logic retrace_blank_out,     // blanking
  output logic line_sync_out,         // horizontal sync
  output logic frame_sync_out,        // vertical sync
  output logic composite_sync_out,    // composite sync
  output logic cursor_marker_out,     // cursor video
  output logic pixel_out,             // serial dot video
  output logic dot_tick_out           // one pulse per dot period
);
  localparam int unsigned ACC_W = 17;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(raster_pkg::DOT_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(raster_pkg::CLK_KHZ);
  localparam logic [2:0] LAST_PHASE = 3'(raster_pkg::DOTS_PER_CHAR - 1);
  localparam logic [2:0] CPU_PHASE = 3'(raster_pkg::DOTS_PER_CHAR / 2);

  typedef enum {SLOT_IDLE, SLOT_ACTIVE} slot_state_t;

  // ==========================================================
  // registers
  logic enable, frame_50, armed;
  logic [6:0] htotal, hs_start, hs_width, vis_cols, cursor_col;
  logic [4:0] vis_rows, cursor_row;
  logic [3:0] scans;
  logic [9:0] blank_lines, vs_start, vs_width;
  logic [6:0] col;
  logic [3:0] scan;
  logic [4:0] row;
  logic [9:0] line;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire setup_ph = psel && !penable;
  wire write_now = psel && penable && pready && pwrite;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enable <= 1'b0;
      frame_50 <= 1'b0;
      htotal <= raster_pkg::RST_HTOTAL;
      hs_start <= raster_pkg::RST_HSYNC_START;
      hs_width <= raster_pkg::RST_HSYNC_WIDTH;
      vis_cols <= raster_pkg::RST_VIS_COLS; // see [R3]
      vis_rows <= raster_pkg::RST_VIS_ROWS;
      scans <= raster_pkg::RST_SCANS;
      blank_lines <= raster_pkg::RST_BLANK_LINES; // see [R4]
      vs_start <= raster_pkg::RST_VSYNC_START;
      vs_width <= raster_pkg::RST_VSYNC_WIDTH;
      cursor_col <= 7'h00;
      cursor_row <= 5'h00;
    end else if (write_now) begin // see [R10]
      if (hit(paddr, raster_pkg::OFS_CTRL)) begin
        enable <= pwdata[raster_pkg::CTRL_ENABLE_BIT];
        frame_50 <= pwdata[raster_pkg::CTRL_FRAME50_BIT];
      end
      if (hit(paddr, raster_pkg::OFS_HTOTAL)) htotal <= pwdata[6:0];
      if (hit(paddr, raster_pkg::OFS_HSYNC_START)) hs_start <= pwdata[6:0];
      if (hit(paddr, raster_pkg::OFS_HSYNC_WIDTH)) hs_width <= pwdata[6:0];
      if (hit(paddr, raster_pkg::OFS_VIS_COLS)) vis_cols <= pwdata[6:0];
      if (hit(paddr, raster_pkg::OFS_VIS_ROWS)) vis_rows <= pwdata[4:0];
      if (hit(paddr, raster_pkg::OFS_SCANS)) scans <= pwdata[3:0];
      if (hit(paddr, raster_pkg::OFS_BLANK_LINES)) blank_lines <= pwdata[9:0];
      if (hit(paddr, raster_pkg::OFS_VSYNC_START)) vs_start <= pwdata[9:0];
      if (hit(paddr, raster_pkg::OFS_VSYNC_WIDTH)) vs_width <= pwdata[9:0];
      if (hit(paddr, raster_pkg::OFS_CURSOR_COL)) cursor_col <= pwdata[6:0];
      if (hit(paddr, raster_pkg::OFS_CURSOR_ROW)) cursor_row <= pwdata[4:0];
    end
  end

  // answer one cycle after setup; read data is taken from the state at setup
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      case (paddr)
        raster_pkg::OFS_CTRL: prdata <= {30'h0, frame_50, enable};
        raster_pkg::OFS_HTOTAL: prdata <= {25'h0, htotal};
        raster_pkg::OFS_HSYNC_START: prdata <= {25'h0, hs_start};
        raster_pkg::OFS_HSYNC_WIDTH: prdata <= {25'h0, hs_width};
        raster_pkg::OFS_VIS_COLS: prdata <= {25'h0, vis_cols};
        raster_pkg::OFS_VIS_ROWS: prdata <= {27'h0, vis_rows};
        raster_pkg::OFS_SCANS: prdata <= {28'h0, scans};
        raster_pkg::OFS_BLANK_LINES: prdata <= {22'h0, blank_lines};
        raster_pkg::OFS_VSYNC_START: prdata <= {22'h0, vs_start};
        raster_pkg::OFS_VSYNC_WIDTH: prdata <= {22'h0, vs_width};
        raster_pkg::OFS_CURSOR_COL: prdata <= {25'h0, cursor_col};
        raster_pkg::OFS_CURSOR_ROW: prdata <= {27'h0, cursor_row};
        raster_pkg::OFS_STATUS: prdata <= {5'h0, armed, line, row, scan, col};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= !pwrite;
        end
      endcase
      if (pwrite && paddr > raster_pkg::OFS_STATUS) pslverr <= 1'b1;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // dot and character enables
  logic [ACC_W-1:0] acc;
  logic dot_en;
  logic [2:0] phase;
  wire [ACC_W-1:0] acc_sum = acc + ACC_STEP;

  always_ff @(posedge clk_in) begin // see [R1]
    if (reset_in) begin
      acc <= '0;
      dot_en <= 1'b0;
    end else if (acc_sum >= ACC_WRAP) begin
      acc <= acc_sum - ACC_WRAP;
      dot_en <= 1'b1;
    end else begin
      acc <= acc_sum;
      dot_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin // see [R2]
    if (reset_in) phase <= 3'h0;
    else if (dot_en) phase <= phase + 3'h1;
  end

  wire char_en = dot_en && phase == LAST_PHASE;

  // ==========================================================
  // raster counters
  wire [9:0] vis_lines = 10'(vis_rows * scans);
  wire [9:0] blank_eff = frame_50 ? raster_pkg::BLANK_LINES_50HZ : blank_lines; // see [R5]
  wire [9:0] vtotal = vis_lines + blank_eff;
  wire in_vis = line < vis_lines;
  wire line_end = char_en && col >= htotal - 7'h01;

  // columns run through blanking so each line has the same length
  always_ff @(posedge clk_in) begin // see [R12] [R6]
    if (reset_in) col <= 7'h00;
    else if (line_end) col <= 7'h00;
    else if (char_en) col <= col + 7'h01;
  end

  always_ff @(posedge clk_in) begin // see [R20] [R7] [R8]
    if (reset_in) begin
      line <= 10'h000;
      scan <= 4'h0;
      row <= 5'h00;
    end else if (line_end) begin
      if (line >= vtotal - 10'h001) begin
        line <= 10'h000;
        scan <= 4'h0;
        row <= 5'h00;
      end else begin
        line <= line + 10'h001;
        if (in_vis && scan == scans - 4'h1) begin
          scan <= 4'h0;
          row <= row + 5'h01;
        end else if (in_vis) begin
          scan <= scan + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin // see [R22]
    if (reset_in) armed <= 1'b0;
    else armed <= enable;
  end

  // ==========================================================
  // raw timing signals, two matching stages, one common output stage
  wire [9:0] vline = line - vis_lines;
  wire hblank = col >= vis_cols;
  wire hsync_raw = col >= hs_start && col < hs_start + hs_width; // see [R13]
  wire vsync_raw = !in_vis && vline >= vs_start && vline < vs_start + vs_width;
  wire blank_raw = hblank || !in_vis; // see [R9]
  wire cursor_raw = col == cursor_col && row == cursor_row && !blank_raw; // see [R11]
  logic [3:0] ctl_s1, ctl_s2;

  always_ff @(posedge clk_in) begin // see [R15]
    if (reset_in) begin
      ctl_s1 <= 4'h1;
      ctl_s2 <= 4'h1;
    end else if (char_en) begin
      ctl_s1 <= {cursor_raw, vsync_raw, hsync_raw, blank_raw};
      ctl_s2 <= ctl_s1;
    end
  end

  always_ff @(posedge clk_in) begin // see [R15] [R22] [R9]
    if (reset_in) begin
      retrace_blank_out <= 1'b1;
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      composite_sync_out <= 1'b0;
      cursor_marker_out <= 1'b0;
    end else if (char_en) begin
      retrace_blank_out <= ctl_s2[0] || !armed;
      line_sync_out <= ctl_s2[1] && armed;
      frame_sync_out <= ctl_s2[2] && armed;
      composite_sync_out <= (ctl_s2[1] ^ ctl_s2[2]) && armed;
      cursor_marker_out <= ctl_s2[3] && armed;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cell_column_count_out <= 7'h00;
      scan_line_count_out <= 4'h0;
      text_row_count_out <= 5'h00;
      dot_tick_out <= 1'b0;
    end else begin
      cell_column_count_out <= col;
      scan_line_count_out <= scan;
      text_row_count_out <= row;
      dot_tick_out <= dot_en;
    end
  end

  // ==========================================================
  // pixel pipeline: latch data, address rom next cell, load shifter
  logic [7:0] disp_data, char_latch, shifter;
  logic [3:0] scan_d;

  always_ff @(posedge clk_in) begin // see [R14]
    if (reset_in) begin
      char_latch <= 8'h00;
      scan_d <= 4'h0;
      rom_addr_out <= 11'h000;
      shifter <= 8'h00;
      pixel_out <= 1'b0;
    end else if (char_en) begin
      char_latch <= disp_data;
      scan_d <= scan;
      rom_addr_out <= {char_latch[6:0], scan_d};
      shifter <= rom_data_in;
      pixel_out <= 1'b0;
    end else if (dot_en) begin
      shifter <= {shifter[6:0], 1'b0};
      pixel_out <= shifter[7];
    end
  end

  // ==========================================================
  // cpu strobes: three flops, a strobe counts as low once the last two are low
  logic [2:0] sel_sync, wr_sync, rd_sync;
  logic req_seen, pending, pend_wr;
  slot_state_t slot;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_sync <= 3'h7;
      wr_sync <= 3'h7;
      rd_sync <= 3'h7;
    end else begin
      sel_sync <= {sel_sync[1:0], display_select_n_in};
      wr_sync <= {wr_sync[1:0], io_write_n_in};
      rd_sync <= {rd_sync[1:0], io_read_n_in};
    end
  end

  wire sel_ok = !sel_sync[1] && !sel_sync[2];
  wire wr_ok = !wr_sync[1] && !wr_sync[2];
  wire rd_ok = !rd_sync[1] && !rd_sync[2];
  wire req_now = sel_ok && (wr_ok || rd_ok);
  wire req_rise = req_now && !req_seen;
  wire slot_done = slot == SLOT_ACTIVE && dot_en && phase == LAST_PHASE;

  // a new request in the cycle the old one retires wins over the clear
  always_ff @(posedge clk_in) begin // see [R21]
    if (reset_in) begin
      req_seen <= 1'b0;
      pending <= 1'b0;
      pend_wr <= 1'b0;
      wait_out <= 1'b0;
    end else begin
      req_seen <= req_now;
      if (req_rise) begin
        pending <= 1'b1;
        pend_wr <= wr_ok;
        wait_out <= 1'b1;
      end else if (slot_done) begin
        pending <= 1'b0;
        wait_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // memory slots: phases 0-3 display read, phases 4-7 cpu access
  always_ff @(posedge clk_in) begin // see [R16] [R23]
    if (reset_in) begin
      slot <= SLOT_IDLE;
      vram_addr_out <= 12'h000;
      vram_wdata_out <= 8'h00;
      vram_we_out <= 1'b0;
      disp_data <= 8'h00;
      cpu_rdata_out <= 8'h00;
    end else if (dot_en) begin
      case (phase)
        3'h0: vram_addr_out <= {row, col}; // see [R18] [R19]
        3'h3: disp_data <= vram_rdata_in;
        CPU_PHASE: begin
          if (pending && !slot_done) begin // see [R17] [R19]
            slot <= SLOT_ACTIVE;
            vram_addr_out <= cpu_addr_in;
            vram_wdata_out <= cpu_wdata_in;
            vram_we_out <= pend_wr;
          end
        end
        LAST_PHASE: begin
          if (slot == SLOT_ACTIVE) begin
            if (!vram_we_out) cpu_rdata_out <= vram_rdata_in;
            slot <= SLOT_IDLE;
            vram_we_out <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // checks
  logic [3:0] dots_since_char;
  always_ff @(posedge clk_in) begin
    if (reset_in || char_en) dots_since_char <= 4'h0;
    else if (dot_en) dots_since_char <= dots_since_char + 4'h1;
  end

  dot_spacing_a: assert property (@(posedge clk_in) disable iff (reset_in)
    dot_en |=> !dot_en [*7]) else $error("dot enables too close"); // see [R1]
  char_period_a: assert property (@(posedge clk_in) disable iff (reset_in)
    char_en |-> dots_since_char == 4'h7) else $error("char not every 8 dots"); // see [R2]
  col_wrap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    line_end |=> col == 7'h00) else $error("column did not wrap"); // see [R12]
  scan_wrap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    line_end && in_vis && scan == scans - 4'h1 && line != vtotal - 10'h001
    |=> scan == 4'h0 && row == $past(row) + 5'h01) else $error("scan wrap wrong"); // see [R7]
  unarmed_quiet_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !armed && !$past(armed) |-> !line_sync_out && !frame_sync_out)
    else $error("sync while unprogrammed"); // see [R22]
  blank_pipe_a: assert property (@(posedge clk_in) disable iff (reset_in)
    char_en && armed |=> retrace_blank_out == $past(ctl_s2[0]))
    else $error("blank stage mismatch"); // see [R15]
  wait_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    req_rise |=> wait_out [*2]) else $error("wait dropped early"); // see [R21]
  cpu_slot_a: assert property (@(posedge clk_in) disable iff (reset_in)
    vram_we_out |-> phase >= CPU_PHASE) else $error("write outside cpu half"); // see [R16]
  refresh_addr_a: assert property (@(posedge clk_in) disable iff (reset_in)
    dot_en && phase == 3'h0 |=> vram_addr_out == {$past(row), $past(col)})
    else $error("refresh address wrong"); // see [R18]
  idle_slot_a: assert property (@(posedge clk_in) disable iff (reset_in)
    dot_en && phase == CPU_PHASE && !pending |=> !vram_we_out && slot == SLOT_IDLE)
    else $error("cpu slot used while idle"); // see [R17]

  cpu_write_c: cover property (@(posedge clk_in) disable iff (reset_in)
    vram_we_out ##1 !vram_we_out);
  frame_wrap_c: cover property (@(posedge clk_in) disable iff (reset_in)
    line_end && line == vtotal - 10'h001);
  cursor_c: cover property (@(posedge clk_in) disable iff (reset_in) cursor_marker_out);
  apb_err_c: cover property (@(posedge clk_in) disable iff (reset_in) pslverr);
endmodule

`default_nettype wire

// ---- raster_pkg.sv ----
// Purpose: constants shared by the character raster timing block
// Assumes: 100 MHz system clock, APB register access, 32-bit data words
// Notes: offsets are byte addresses, one aligned word per register
package raster_pkg;
  // ==========================================================
  // clocking
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned DOT_KHZ = 12324;
  localparam int unsigned DOTS_PER_CHAR = 8;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HTOTAL = 8'h04;
  localparam logic [7:0] OFS_HSYNC_START = 8'h08;
  localparam logic [7:0] OFS_HSYNC_WIDTH = 8'h0c;
  localparam logic [7:0] OFS_VIS_COLS = 8'h10;
  localparam logic [7:0] OFS_VIS_ROWS = 8'h14;
  localparam logic [7:0] OFS_SCANS = 8'h18;
  localparam logic [7:0] OFS_BLANK_LINES = 8'h1c;
  localparam logic [7:0] OFS_VSYNC_START = 8'h20;
  localparam logic [7:0] OFS_VSYNC_WIDTH = 8'h24;
  localparam logic [7:0] OFS_CURSOR_COL = 8'h28;
  localparam logic [7:0] OFS_CURSOR_ROW = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // ==========================================================
  // field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_FRAME50_BIT = 1;
  // ==========================================================
  // reset values and the fixed 50 Hz blank line count
  localparam logic [6:0] RST_HTOTAL = 7'h64;
  localparam logic [6:0] RST_HSYNC_START = 7'h54;
  localparam logic [6:0] RST_HSYNC_WIDTH = 7'h08;
  localparam logic [6:0] RST_VIS_COLS = 7'h50;
  localparam logic [4:0] RST_VIS_ROWS = 5'h18;
  localparam logic [3:0] RST_SCANS = 4'ha;
  localparam logic [9:0] RST_BLANK_LINES = 10'h106;
  localparam logic [9:0] BLANK_LINES_50HZ = 10'h138;
  localparam logic [9:0] RST_VSYNC_START = 10'h004;
  localparam logic [9:0] RST_VSYNC_WIDTH = 10'h003;
endpackage

// ---- raster_mem_model.sv ----
// Purpose: video memory and character rom seen from the raster block
// Assumes: one clock; both reads are registered
// Notes: the rom pattern is a fixed function of its address
`timescale 1ns/1ps
`default_nettype none
module raster_mem_model (
  input wire logic clk_in, // system clock
  input wire logic [11:0] vram_addr_in, // memory address
  input wire logic [7:0] vram_wdata_in, // write data
  input wire logic vram_we_in, // write enable
  output logic [7:0] vram_rdata_out, // read data
  input wire logic [10:0] rom_addr_in, // rom address
  output logic [7:0] rom_data_out // rom dots
);
  logic [7:0] mem [0:4095];
  // ==========================================================
  // memory and rom
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end
  always @(posedge clk_in) begin
    if (vram_we_in === 1'b1) begin
      mem[vram_addr_in] <= vram_wdata_in;
    end
    vram_rdata_out <= mem[vram_addr_in];
    rom_data_out <= rom_addr_in[7:0] ^ 8'hc3;
  end
endmodule
`default_nettype wire

// ---- video_raster_timing_test.sv ----
// Purpose: self-checking bench for the character raster block
// Assumes: timing shrunk over apb so a frame is 8 lines of 20 cells
// Notes: dot rate is jittered, so line length is measured in dot ticks
`timescale 1ns/1ps
`default_nettype none
module video_raster_timing_test;
  typedef struct {logic [7:0] a; logic [31:0] v;} row_t;
  logic clk_in, reset_in, psel, penable, pwrite, pready, pslverr, e, meas;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic display_select_n_in, io_write_n_in, io_read_n_in, wait_out, vram_we_out;
  logic retrace_blank_out, line_sync_out, frame_sync_out, composite_sync_out;
  logic cursor_marker_out, pixel_out, dot_tick_out, hs_q, vs_q;
  logic [11:0] cpu_addr_in, vram_addr_out;
  logic [7:0] cpu_wdata_in, cpu_rdata_out, vram_wdata_out, vram_rdata_in, rom_data_in;
  logic [10:0] rom_addr_out;
  logic [6:0] cell_column_count_out;
  logic [3:0] scan_line_count_out;
  logic [4:0] text_row_count_out;
  int errors = 0, num_checks = 0, dots = 0, last_dots = 0, lines = 0, last_lines = 0;
  int hs_total = 0, cur_seen = 0, bad = 0, col_max = 0, scan_max = 0, row_max = 0, pix = 0;
  row_t rst_rows[10] = '{'{8'h00, 32'h0},
    '{raster_pkg::OFS_HTOTAL, 32'(raster_pkg::RST_HTOTAL)},
    '{raster_pkg::OFS_HSYNC_START, 32'(raster_pkg::RST_HSYNC_START)},
    '{raster_pkg::OFS_HSYNC_WIDTH, 32'(raster_pkg::RST_HSYNC_WIDTH)},
    '{raster_pkg::OFS_VIS_COLS, 32'(raster_pkg::RST_VIS_COLS)},
    '{raster_pkg::OFS_VIS_ROWS, 32'(raster_pkg::RST_VIS_ROWS)},
    '{raster_pkg::OFS_SCANS, 32'(raster_pkg::RST_SCANS)},
    '{raster_pkg::OFS_BLANK_LINES, 32'(raster_pkg::RST_BLANK_LINES)},
    '{raster_pkg::OFS_VSYNC_START, 32'(raster_pkg::RST_VSYNC_START)},
    '{raster_pkg::OFS_VSYNC_WIDTH, 32'(raster_pkg::RST_VSYNC_WIDTH)}};
  // small raster: 20 cells, 2 rows of 2 scans, 4 blank lines
  row_t prog[10] = '{'{8'h04, 32'd20}, '{8'h08, 32'd16}, '{8'h0c, 32'd2},
    '{8'h10, 32'd16}, '{8'h14, 32'd2}, '{8'h18, 32'd2}, '{8'h1c, 32'd4},
    '{8'h20, 32'd1}, '{8'h24, 32'd1}, '{8'h28, 32'd3}};
  video_raster_timing uut (.clk_in, .reset_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .display_select_n_in, .io_write_n_in, .io_read_n_in,
    .cpu_addr_in, .cpu_wdata_in, .cpu_rdata_out, .wait_out, .vram_addr_out, .vram_wdata_out,
    .vram_we_out, .vram_rdata_in, .rom_addr_out, .rom_data_in, .cell_column_count_out,
    .scan_line_count_out, .text_row_count_out, .retrace_blank_out, .line_sync_out,
    .frame_sync_out, .composite_sync_out, .cursor_marker_out, .pixel_out, .dot_tick_out);
  raster_mem_model mem (.clk_in, .vram_addr_in(vram_addr_out), .vram_wdata_in(vram_wdata_out),
    .vram_we_in(vram_we_out), .vram_rdata_out(vram_rdata_in), .rom_addr_in(rom_addr_out),
    .rom_data_out(rom_data_in));
  // ==========================================================
  // monitor: dot ticks per line, lines per frame, sync sanity
  always @(posedge clk_in) begin
    hs_q <= line_sync_out;
    vs_q <= frame_sync_out;
    if (line_sync_out === 1'b1 && hs_q === 1'b0) begin
      last_dots <= dots;
      dots <= int'(dot_tick_out === 1'b1);
      hs_total <= hs_total + 1;
    end else begin
      dots <= dots + int'(dot_tick_out === 1'b1);
    end
    if (frame_sync_out === 1'b1 && vs_q === 1'b0) begin
      last_lines <= lines;
      lines <= int'(line_sync_out === 1'b1 && hs_q === 1'b0);
    end else begin
      lines <= lines + int'(line_sync_out === 1'b1 && hs_q === 1'b0);
    end
    if (meas) begin
      cur_seen <= cur_seen + int'(cursor_marker_out === 1'b1);
      pix <= pix + int'(pixel_out === 1'b1);
      if (composite_sync_out !== (line_sync_out ^ frame_sync_out) ||
          (line_sync_out === 1'b1 && retrace_blank_out !== 1'b1)) begin
        bad <= bad + 1;
      end
      col_max <= (cell_column_count_out > col_max) ? cell_column_count_out : col_max;
      scan_max <= (scan_line_count_out > scan_max) ? scan_line_count_out : scan_max;
      row_max <= (text_row_count_out > row_max) ? text_row_count_out : row_max;
    end
  end
  // ==========================================================
  // tasks
  task chk(input string s, input logic [31:0] x, input logic [31:0] y);
    num_checks++;
    if (y !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, x, y);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_ready", 1, n < 20);
    @(posedge clk_in);
  endtask
  task cpu(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cpu_addr_in <= a;
    cpu_wdata_in <= d;
    display_select_n_in <= 1'b0;
    io_write_n_in <= !w;
    io_read_n_in <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_out !== 1'b1 && n < 20);
    chk("wait_raised", 1, n < 20);
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_out !== 1'b0 && n < 400);
    chk("wait_done", 1, n < 400);
    display_select_n_in <= 1'b1;
    io_write_n_in <= 1'b1;
    io_read_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
  task frame_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!(frame_sync_out === 1'b1 && vs_q === 1'b0) && n < 20000);
    chk("frame_seen", 1, n < 20000);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    errors++;
    end_sim;
  end
  initial begin
    {reset_in, display_select_n_in, io_write_n_in, io_read_n_in} = 4'hf;
    {psel, penable, pwrite, meas, paddr, pwdata} = '0;
    {cpu_addr_in, cpu_wdata_in} = '0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    chk("col_reset", 0, cell_column_count_out);
    chk("row_reset", 0, {scan_line_count_out, text_row_count_out});
    chk("blank_reset", 1, retrace_blank_out);
    chk("sync_reset", 0, {line_sync_out, frame_sync_out, composite_sync_out});
    foreach (rst_rows[i]) begin
      apb(1'b0, rst_rows[i].a, 32'h0);
      chk($sformatf("reg_%h", rst_rows[i].a), rst_rows[i].v, q);
    end
    $display("test reset values done");
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped_read", 1, {q, e});
    apb(1'b1, 8'h40, 32'h1);
    chk("unmapped_write_err", 1, e);
    foreach (prog[i]) begin
      apb(1'b1, prog[i].a, prog[i].v);
    end
    apb(1'b0, raster_pkg::OFS_CURSOR_COL, 32'h0);
    chk("cursor_col_rd", 3, q);
    repeat (2000) @(posedge clk_in);
    chk("sync_idle", 0, hs_total);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_frame50", 2, q);
    $display("test register port done");
    apb(1'b1, raster_pkg::OFS_CTRL, 32'h1);
    frame_wait;
    meas <= 1'b1;
    frame_wait;
    frame_wait;
    meas <= 1'b0;
    chk("dots_per_line", 160, last_dots);
    chk("lines_per_frame", 8, last_lines);
    chk("col_max", 19, col_max);
    chk("scan_max", 1, scan_max);
    chk("row_max", 2, row_max);
    chk("sync_blank", 0, bad);
    chk("cursor_shown", 1, cur_seen > 0);
    chk("pixels_seen", 1, pix > 0);
    $display("test raster done");
    apb(1'b1, raster_pkg::OFS_CURSOR_ROW, 32'd20);
    frame_wait;
    cur_seen = 0;
    meas <= 1'b1;
    frame_wait;
    meas <= 1'b0;
    chk("cursor_off_row", 0, cur_seen);
    $display("test cursor done");
    cpu(1'b1, 12'h123, 8'ha5);
    cpu(1'b1, 12'h124, 8'h3c);
    chk("mem_123", 8'ha5, mem.mem[12'h123]);
    chk("mem_124", 8'h3c, mem.mem[12'h124]);
    cpu(1'b0, 12'h123, 8'h00);
    chk("cpu_read_123", 8'ha5, cpu_rdata_out);
    cpu(1'b0, 12'h010, 8'h00);
    chk("cpu_read_010", 8'h4a, cpu_rdata_out);
    $display("test cpu access done");
    end_sim;
  end
endmodule
`default_nettype wire
